// ===== verilog/gpio_map.vh
// Purpose: Constants for the general-purpose I/O port block
// Assumes: APB word addressing, byte address = index * 4
// Notes:   Port order in 64-bit vectors is P0,P1,P2,P3,P4,P5,P6,P8
`ifndef GPIO_MAP_VH
`define GPIO_MAP_VH

// Register indexes
`define IDX_DATA_FIRST   6'h00
`define IDX_DATA_LAST    6'h07
`define IDX_DIR_FIRST    6'h08
`define IDX_DIR_LAST     6'h0F
`define IDX_PULLUP       6'h10
`define IDX_DRV_GROUP    6'h11
`define IDX_P1_DRV       6'h12
`define IDX_P2_DRV       6'h13
`define IDX_VTH          6'h14
`define IDX_CTRL         6'h15

// Bits that own a direction bit and an output latch
`define DIR_MASK         64'h7FFF_DFF8_FFFF_FFFF
// Bits whose pin level can be read (adds the input-only pin)
`define READ_MASK        64'h7FFF_DFFC_FFFF_FFFF

// Special pins of port 4 in the 64-bit vectors
`define BIT_ADC_IN       34
`define BIT_SUB_IN       35
`define BIT_SUB_OUT      36
`define BIT_MAIN_IN      38
`define BIT_MAIN_OUT     39

// Control register fields
`define CTRL_SUBCLK      0
`define CTRL_MAINCLK     1
`define CTRL_ADC_P42     2
`define CTRL_WIDTH       3

// Threshold codes: 0.35, 0.50, 0.70 of supply
`define VTH_035          2'h0
`define VTH_050          2'h1
`define VTH_070          2'h2

// Reset values
`define RST_LATCH        64'h0000_0000_0000_0000
`define RST_DIR          64'h0000_0000_0000_0000
`define RST_REG16        16'h0000
`define RST_REG8         8'h00
`define RST_CTRL         3'h0

`endif

// ===== verilog/gpio_pin_sync.v
// Purpose: Two-stage synchroniser for the pin input levels
// Assumes: Pins change with no relation to pclk
// Notes:   The first stage feeds the second stage only
`timescale 1ns/1ns

module gpio_pin_sync #(
  parameter WIDTH = 64
) (
  input  wire             pclk,
  input  wire             presetn,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_ff;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_ff  <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end

endmodule // gpio_pin_sync

// ===== verilog/gpio_port.v
// Purpose: General-purpose I/O ports P0..P6 and P8 behind an APB slave
// Assumes: 125 MHz pclk, 8-bit and 16-bit registers in the low bits of each word
// Notes:   Pad controls are registered, so they follow a write by one cycle
`timescale 1ns/1ns
`include "gpio_map.vh"
`include "gpio_bitmask.vh"

////////////////////////////////////////////////////////////////////////////////
// Function
// - Provide 59 general-purpose I/O pins across ports 0 to 6 and 8, excluding unimplemented positions.
// - Every implemented pin except port 4 bit 2 has its own direction bit, zero for input and one for output.
// - A data read returns the synchronised pin level for every bit in input mode.
// - A data read returns the output latch for every bit in output mode.
// - A data write always updates the latch, which drives the pin only in output mode.
// - Port 4 bits 0 and 1, port 5 bit 5 and port 8 bit 7 have no storage and read as zero.
// - While the sub-clock oscillator owns port 4 bits 3 and 4 they read one and never drive.
// - While the main oscillator owns port 4 bits 6 and 7 they read one and never drive.
// - Port 4 bit 2 is input only, with no direction bit, and is read only when the converter leaves it.
// - Pull-ups are chosen per group of four and only connect to pins in input mode, port 4 bit 3 alone.
// - Drive strength is chosen per group of four, with port 4 bit 3 on its own.
// - Ports 1 and 2 choose drive strength bit by bit.
// - Each port selects an input threshold of 0.35, 0.50 or 0.70 of supply.
module gpio_port (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [63:0] pin_in,
  output reg  [63:0] pin_out,
  output reg  [63:0] pin_oe,
  output reg  [63:0] pullup_en,
  output reg  [63:0] drive_high,
  output reg  [15:0] vth_sel
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register state

  reg  [63:0] latch_ff;
  reg  [63:0] dir_ff;
  reg  [15:0] pullup_sel_ff;
  reg  [15:0] drv_grp_ff;
  reg  [7:0]  p1_drv_ff;
  reg  [7:0]  p2_drv_ff;
  reg  [15:0] vth_ff;
  reg  [`CTRL_WIDTH-1:0] ctrl_ff;

  wire [63:0] pin_sync;
  wire [5:0]  idx;
  wire        setup;
  wire        access;
  wire        bad_addr;

  reg  [63:0] osc_mask;
  wire [63:0] read_vec;
  wire [63:0] nxt_oe;
  wire [63:0] nxt_pullup;
  wire [63:0] nxt_drive;
  wire [15:0] nxt_vth;
  reg  [7:0]  rd_byte;
  reg         rd_hit;

  assign idx    = paddr[7:2];
  assign setup  = psel & ~penable;
  assign access = psel & penable & pready;
  // Bits above the register window or below the word boundary are refused, not aliased
  assign bad_addr = (paddr[11:8] != 4'h0) | (paddr[1:0] != 2'h0);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin input synchroniser
  // Reads lag the pins by two clocks; that is the price of never returning a metastable bit

  gpio_pin_sync #(
    .WIDTH    (64)
  ) gpio_pin_sync_i (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Oscillator ownership of port 4 pins
  // An owned pin reads one and its driver stays off whatever its direction bit holds

  always @*
  begin
    osc_mask = 64'h0000_0000_0000_0000;
    osc_mask[`BIT_SUB_IN]   = ctrl_ff[`CTRL_SUBCLK];
    osc_mask[`BIT_SUB_OUT]  = ctrl_ff[`CTRL_SUBCLK];
    osc_mask[`BIT_MAIN_IN]  = ctrl_ff[`CTRL_MAINCLK];
    osc_mask[`BIT_MAIN_OUT] = ctrl_ff[`CTRL_MAINCLK];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per-bit read value and pad controls

  genvar g;
  generate
    for (g = 0; g < 64; g = g + 1)
    begin : g_bit
      reg rd_bit;
      reg oe_bit;
      reg pu_bit;
      reg drv_bit;

      always @*
      begin
        if (!`READ_MASK_BIT(g))
          rd_bit = 1'b0;
        else if (osc_mask[g])
          rd_bit = 1'b1;
        else if (g == `BIT_ADC_IN)
          rd_bit = pin_sync[g] & ~ctrl_ff[`CTRL_ADC_P42];
        else if (dir_ff[g])
          rd_bit = latch_ff[g];
        else
          rd_bit = pin_sync[g];
      end

      // The low nibble of port 4 holds only pin 3, so its group bit selects that pin alone
      always @*
      begin
        oe_bit = dir_ff[g] & `DIR_MASK_BIT(g) & ~osc_mask[g];
        pu_bit = pullup_sel_ff[g/4] & ~dir_ff[g] & `DIR_MASK_BIT(g) & ~osc_mask[g];
        if (g / 8 == 1)
          drv_bit = p1_drv_ff[g%8];
        else if (g / 8 == 2)
          drv_bit = p2_drv_ff[g%8];
        else
          drv_bit = drv_grp_ff[g/4] & `DIR_MASK_BIT(g);
      end

      assign read_vec[g]   = rd_bit;
      assign nxt_oe[g]     = oe_bit;
      assign nxt_pullup[g] = pu_bit;
      assign nxt_drive[g]  = drv_bit;
    end

    for (g = 0; g < 8; g = g + 1)
    begin : g_port
      reg [1:0] vth_code;

      // Reserved code falls back to the lowest threshold
      always @*
      begin
        if (vth_ff[2*g+1 -: 2] == 2'h3)
          vth_code = `VTH_035;
        else
          vth_code = vth_ff[2*g+1 -: 2];
      end

      assign nxt_vth[2*g+1 -: 2] = vth_code;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Read decode

  always @*
  begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    if (idx <= `IDX_DATA_LAST)
      rd_byte = read_vec[idx[2:0]*8 +: 8];
    else if (idx <= `IDX_DIR_LAST)
      rd_byte = dir_ff[idx[2:0]*8 +: 8];
    else if (idx == `IDX_PULLUP)
      rd_byte = 8'h00;
    else if (idx == `IDX_DRV_GROUP)
      rd_byte = 8'h00;
    else if (idx == `IDX_P1_DRV)
      rd_byte = p1_drv_ff;
    else if (idx == `IDX_P2_DRV)
      rd_byte = p2_drv_ff;
    else if (idx == `IDX_VTH)
      rd_byte = 8'h00;
    else if (idx == `IDX_CTRL)
      rd_byte = {5'h00, ctrl_ff};
    else
      rd_hit = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave: no wait states, answer registered in the setup cycle

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      pready  <= 1'b1;
      pslverr <= ~rd_hit | bad_addr;
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Read data stands only in the access cycle; a refused access returns zero even when its
  // low index bits would select a register
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (!setup)
      prdata <= 32'h0000_0000;
    else if (~rd_hit | bad_addr)
      prdata <= 32'h0000_0000;
    else if (idx == `IDX_PULLUP || idx == `IDX_DRV_GROUP || idx == `IDX_VTH)
      prdata <= {16'h0000, wide_read(idx, pullup_sel_ff, drv_grp_ff, vth_ff)};
    else
      prdata <= {24'h00_0000, rd_byte};
  end

  // The pull-up and drive group registers carry one bit per nibble of the eight ports; the threshold register two bits per port
  function [15:0] wide_read;
    input [5:0]  sel;
    input [15:0] pu;
    input [15:0] dg;
    input [15:0] vt;
    begin
      if (sel == `IDX_PULLUP)
        wide_read = pu;
      else if (sel == `IDX_DRV_GROUP)
        wide_read = dg;
      else
        wide_read = vt;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Register writes, taken at the access edge only

  wire wr_ok;

  assign wr_ok = access & pwrite & ~pslverr;

  // Port latches and direction bits; bits without storage are masked off on the way in
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      latch_ff <= `RST_LATCH;
      dir_ff   <= `RST_DIR;
    end
    else if (wr_ok)
    begin
      if (idx <= `IDX_DATA_LAST)
        latch_ff[idx[2:0]*8 +: 8] <= pwdata[7:0] & dir_mask_byte(idx[2:0]);
      else if (idx <= `IDX_DIR_LAST)
        dir_ff[idx[2:0]*8 +: 8] <= pwdata[7:0] & dir_mask_byte(idx[2:0]);
    end
  end

  // Pad configuration and oscillator ownership
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pullup_sel_ff <= `RST_REG16;
      drv_grp_ff    <= `RST_REG16;
      p1_drv_ff     <= `RST_REG8;
      p2_drv_ff     <= `RST_REG8;
      vth_ff        <= `RST_REG16;
      ctrl_ff       <= `RST_CTRL;
    end
    else if (wr_ok)
    begin
      if (idx == `IDX_PULLUP)
        pullup_sel_ff <= pwdata[15:0];
      else if (idx == `IDX_DRV_GROUP)
        drv_grp_ff <= pwdata[15:0];
      else if (idx == `IDX_P1_DRV)
        p1_drv_ff <= pwdata[7:0];
      else if (idx == `IDX_P2_DRV)
        p2_drv_ff <= pwdata[7:0];
      else if (idx == `IDX_VTH)
        vth_ff <= pwdata[15:0];
      else if (idx == `IDX_CTRL)
        ctrl_ff <= pwdata[`CTRL_WIDTH-1:0];
    end
  end

  // Storage exists only for the 59 pins with a direction bit
  function [7:0] dir_mask_byte;
    input [2:0] port;
    reg   [63:0] m;
    begin
      m = `DIR_MASK;
      dir_mask_byte = m[port*8 +: 8];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pad control registers; outputs leave straight from flops
  // Pads see one clean edge per change, at the cost of one clock of lag after a write

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_out <= 64'h0000_0000_0000_0000;
      pin_oe  <= 64'h0000_0000_0000_0000;
    end
    else
    begin
      pin_out <= latch_ff & `DIR_MASK;
      pin_oe  <= nxt_oe;
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pullup_en  <= 64'h0000_0000_0000_0000;
      drive_high <= 64'h0000_0000_0000_0000;
      vth_sel    <= 16'h0000;
    end
    else
    begin
      pullup_en  <= nxt_pullup;
      drive_high <= nxt_drive;
      vth_sel    <= nxt_vth;
    end
  end

endmodule // gpio_port

// ===== verilog/gpio_bitmask.vh
// Purpose: Per-bit helpers over the port masks
// Assumes: gpio_map.vh included first
// Notes:   Yields a 1-bit truth value
`ifndef GPIO_BITMASK_VH
`define GPIO_BITMASK_VH
`define READ_MASK_BIT(n) (((`READ_MASK >> (n)) & 64'h0000_0000_0000_0001) != 64'h0000_0000_0000_0000)
`define DIR_MASK_BIT(n) (((`DIR_MASK >> (n)) & 64'h0000_0000_0000_0001) != 64'h0000_0000_0000_0000)
`endif

// ===== testbench/gpio_port_assertions.sv
// Purpose: Port-level checks for gpio_port
// Assumes: gpio_map.vh on the include path
// Notes:   Sees the top ports only
`timescale 1ns/1ns
`include "gpio_map.vh"
module gpio_port_checker (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire [63:0] pin_in,
  input wire [63:0] pin_out,
  input wire [63:0] pin_oe,
  input wire [63:0] pullup_en,
  input wire [63:0] drive_high,
  input wire [15:0] vth_sel
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_bad;
    s_setup ##0 (paddr[11:8] != 4'h0 || paddr[1:0] != 2'h0);
  endsequence
  sequence s_wr_data;
    psel && penable && pready && pwrite && paddr[11:5] == 7'h00;
  endsequence
  a_ready_once: assert property (s_setup |=> pready ##1 !pready) else $error("pready not one cycle");
  a_ready_cause: assert property (pready |-> penable && $past(psel && !penable)) else $error("stray pready");
  a_bad_addr: assert property (s_bad |=> pslverr && (pwrite || prdata == 32'h0)) else $error("no error");
  a_oe_impl: assert property ((pin_oe & ~`DIR_MASK) == 64'h0) else $error("unimplemented pin driven");
  a_out_impl: assert property ((pin_out & ~`DIR_MASK) == 64'h0) else $error("unimplemented latch");
  a_pullup_input: assert property ((pullup_en & pin_oe) == 64'h0) else $error("pull-up on output");
  a_reset_inputs: assert property ($rose(presetn) |-> (pin_oe == 64'h0) [*2]) else $error("driver after reset");
  a_vth_legal: assert property ((vth_sel & (vth_sel >> 1) & 16'h5555) == 16'h0) else $error("bad threshold");
  a_data_no_dir: assert property (s_wr_data |=> $stable(pin_oe)) else $error("data write moved oe");
endmodule // gpio_port_checker
bind gpio_port gpio_port_checker gpio_port_checker_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en),
  .drive_high(drive_high), .vth_sel(vth_sel));

// ===== testbench/gpio_pin_model.sv
// Purpose: Pins and board seen by gpio_port
// Assumes: No contention from the board
// Notes:   Released pins show the pull-up or the board pattern
`timescale 1ns/1ns
module gpio_pin_model (
  input  wire [63:0] pin_out,
  input  wire [63:0] pin_oe,
  input  wire [63:0] pullup_en,
  input  wire [63:0] ext_level,
  output wire [63:0] pin_in
);
  // Board pattern is chosen by the bench so a stale latch looks right on no port but port 6
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & (pullup_en | ext_level));
endmodule // gpio_pin_model

// ===== testbench/general_purpose_io_ports_tb.sv
// Purpose: Self-checking bench for gpio_port
// Assumes: Pad outputs follow a write within two cycles
// Notes:   Pin reads wait four cycles for the synchroniser
`timescale 1ns/1ns
`include "gpio_map.vh"
module general_purpose_io_ports_tb;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0;
  reg  [63:0] ext = 64'h5A3C_96F4_1E87_C3A5;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  wire [63:0] pin_in;
  wire [63:0] pin_out;
  wire [63:0] pin_oe;
  wire [63:0] pullup_en;
  wire [63:0] drive_high;
  wire [15:0] vth_sel;
  reg  [31:0] rd;
  reg         er;
  reg  [63:0] ev;
  integer     errors = 0;
  integer     samples_checked = 0;
  integer     k;
  always #4 pclk = ~pclk;
  gpio_port gpio_port_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en), .drive_high(drive_high), .vth_sel(vth_sel));
  gpio_pin_model gpio_pin_model_i (.pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en),
    .ext_level(ext), .pin_in(pin_in));
  //////////////////////////////////////////////////////////////////////////////
  task check(input [63:0] seen, input [63:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp)
      begin
        errors = errors + 1;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 16)
      begin
        @(posedge pclk);
        n = n + 1;
      end
      if (n == 16)
      begin
        errors = errors + 1;
        final_report;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // Expected data read of port k from the bench's own latch and direction picture
  task read_port(input integer k, input [63:0] lat, input [63:0] dir, input [7:0] force1);
    begin
      apb(1'b0, k * 4, 32'h0);
      ev = ((lat & dir) | (ext & `READ_MASK & ~dir)) >> (8 * k);
      check(rd, {56'h0, ev[7:0] | force1});
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task t_reset_inputs;
    begin
      for (k = 0; k < 8; k = k + 1)
      begin
        apb(1'b0, 12'h020 + k * 4, 32'h0);
        check(rd, 64'h0);
        read_port(k, 64'h0, 64'h0, 8'h00);
      end
      check(pin_oe, 64'h0);
    end
  endtask
  task t_latch_then_output;
    begin
      for (k = 0; k < 8; k = k + 1)
        apb(1'b1, k * 4, 32'h3C);
      read_port(4, 64'h0, 64'h0, 8'h00);
      for (k = 0; k < 8; k = k + 1)
      begin
        apb(1'b1, 12'h020 + k * 4, 32'hFF);
        apb(1'b0, 12'h020 + k * 4, 32'h0);
        ev = `DIR_MASK >> (8 * k);
        check(rd, {56'h0, ev[7:0]});
        read_port(k, {8{8'h3C}}, `DIR_MASK, 8'h00);
      end
      check(pin_oe, `DIR_MASK);
      check(pin_out, {8{8'h3C}} & `DIR_MASK);
    end
  endtask
  task t_oscillators;
    begin
      apb(1'b1, 12'h054, 32'h3);
      read_port(4, {8{8'h3C}}, `DIR_MASK, 8'hD8);
      check(pin_oe & 64'h0000_00D8_0000_0000, 64'h0);
      apb(1'b1, 12'h054, 32'h4);
      apb(1'b0, 12'h010, 32'h0);
      check(rd[2], 1'b0);
      apb(1'b1, 12'h054, 32'h0);
    end
  endtask
  task t_pad_config;
    begin
      for (k = 0; k < 8; k = k + 1)
        apb(1'b1, 12'h020 + k * 4, 32'h0);
      apb(1'b1, 12'h040, 32'h1);
      apb(1'b1, 12'h044, 32'h1);
      apb(1'b1, 12'h048, 32'h5A);
      repeat (4) @(posedge pclk);
      check(pullup_en, 64'hF);
      check(drive_high, 64'h5A0F);
      read_port(0, 64'h0, 64'h0, 8'h0F);
      for (k = 0; k < 4; k = k + 1)
      begin
        apb(1'b1, 12'h050, k);
        @(posedge pclk);
        @(posedge pclk);
        check(vth_sel, (k == 3) ? 64'h0 : k);
      end
    end
  endtask
  task t_unmapped;
    begin
      apb(1'b0, 12'h058, 32'h0);
      check({er, rd}, {1'b1, 32'h0});
      apb(1'b1, 12'h102, 32'hFF);
      check(er, 1'b1);
      apb(1'b0, 12'h100, 32'h0);
      check({er, rd}, {1'b1, 32'h0});
      check(pin_out[7:0], 8'h3C);
    end
  endtask
  task final_report;
    begin
      if (errors == 0 && samples_checked > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_reset_inputs;
    t_latch_then_output;
    t_oscillators;
    t_pad_config;
    t_unmapped;
    final_report;
  end
  initial
  begin
    #200000;
    errors = errors + 1;
    final_report;
  end
endmodule // general_purpose_io_ports_tb
